/* rtl/tbt_core.sv */
/*
 Target bus tester core: drives the target processor bus through the pod,
 signature, I/O mask, handshake and self tests, probe, storage, working
 registers and annunciators. Assumes a synchronous register master on ref_clk;
 all target and probe pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tbt_params.svh"
module tbt_core #(
	parameter int MEM_BYTES = 12288,
	parameter int FLASH_CYC = `TBT_FLASH_MS * 1000 * `TBT_CLK_MHZ
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic tgt_clk,
	output logic [31:0] tgt_addr,
	output logic [31:0] tgt_data_out,
	output logic tgt_data_oe,
	input wire logic [31:0] tgt_data_in,
	input wire logic [15:0] tgt_status_in,
	output logic [7:0] tgt_ctrl_out,
	output logic [7:0] tgt_strobe_out,
	input wire logic [7:0] tgt_hs_fb,
	input wire logic tgt_power_ok,
	input wire logic selftest_plug_in,
	input wire logic probe_in,
	output logic probe_out,
	output logic probe_oe,
	output logic more_ind,
	output logic loop_ind,
	output logic stop_ind,
	output logic program_entry_indicator,
	output logic exec_ind,
	output logic [7:0] disp_first,
	output logic [5:0] disp_count,
	output logic [3:0] disp_line
);
	localparam int SW = 60;
	localparam int MAW = $clog2(MEM_BYTES);

	function automatic logic [15:0] sig_step(input logic [15:0] s, input logic b);
		sig_step = {s[14:0], 1'b0} ^ ((s[15] ^ b) ? `TBT_SIG_POLY : 16'h0000);
	endfunction
	function automatic logic [15:0] sig_word(input logic [15:0] s, input logic [31:0] w);
		logic [15:0] t;
		logic [15:0] f;
		t = s;
		f = w[15:0] ^ w[31:16];
		for (int i = 15; i >= 0; i--) begin
			t = sig_step(t, f[i]);
		end
		sig_word = t;
	endfunction

	// Pin synchronisers; only stage two is read
	logic [SW-1:0] sy1_q, sy2_q;
	logic tclk_d_q;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			// Supply-good starts high, so reset release flags no false supply loss
			sy1_q <= 60'h000000000000004;
			sy2_q <= 60'h000000000000004;
			tclk_d_q <= 1'b0;
		end else if (ce) begin
			sy1_q <= {tgt_clk, tgt_data_in, tgt_status_in, tgt_hs_fb, tgt_power_ok,
				selftest_plug_in, probe_in};
			sy2_q <= sy1_q;
			tclk_d_q <= sy2_q[59];
		end
	end
	wire [31:0] t_data = sy2_q[58:27];
	wire [15:0] t_stat = sy2_q[26:11];
	wire [7:0] t_hsfb = sy2_q[10:3];
	wire t_pwr = sy2_q[2];
	wire t_plug = sy2_q[1];
	wire t_probe = sy2_q[0];
	wire tick = sy2_q[59] & ~tclk_d_q;

	wire wr_cmd = reg_wr && reg_addr == `TBT_OFF_CMD;
	wire wr_mode = reg_wr && reg_addr == `TBT_OFF_MODE;
	wire wr_disp = reg_wr && reg_addr == `TBT_OFF_DISP;
	wire wr_prb = reg_wr && reg_addr == `TBT_OFF_PROBE;
	wire wr_wreg = reg_wr && reg_addr[7:6] == 2'b01 && reg_addr[1:0] == 2'b00;
	wire [3:0] wreg_idx = reg_addr[5:2];
	wire stop_key = wr_mode && reg_wdata[1:0] == 2'b10;

	tbt_pkg::tbt_bus_e st_q;
	tbt_pkg::tbt_op_e op_q;
	tbt_pkg::tbt_run_e run_q;
	tbt_pkg::tbt_mode_e mode_q;
	logic [1:0] ph_q;
	logic [31:0] addr_q, end_q, cur_q, data_q, ones_q, iomask_q;
	logic [15:0] sig_q, sig_exp_q;
	logic mism_q, stfail_q, stdone_q, pwrf_q;
	logic [7:0] hsbad_q, ctrl_q;
	logic [31:0] tgt_addr_q, tgt_dout_q;
	logic tgt_doe_q;
	logic [7:0] strobe_q;

	wire cmd_ok = wr_cmd && reg_wdata[2:0] != tbt_pkg::OP_NONE
		&& (reg_wdata[2:0] != tbt_pkg::OP_SELFTEST || t_plug);
	wire cyc_wr = op_q == tbt_pkg::OP_WRITE
		|| ((op_q == tbt_pkg::OP_IOMASK || op_q == tbt_pkg::OP_SELFTEST) && !ph_q[0]);
	wire [31:0] cyc_wdat = op_q == tbt_pkg::OP_WRITE ? data_q
		: op_q == tbt_pkg::OP_SELFTEST ? `TBT_SELFTEST_PAT : {32{~ph_q[1]}};
	wire [15:0] sig_nx = sig_word(sig_q, t_data);
	wire op_last = op_q == tbt_pkg::OP_ROMSIG ? cur_q == end_q
		: op_q == tbt_pkg::OP_IOMASK ? ph_q == 2'b11
		: op_q == tbt_pkg::OP_SELFTEST ? ph_q == 2'b01 : 1'b1;
	wire restart = op_last && run_q == tbt_pkg::RUN_LOOP;

	// bus engine over the uniform 32-bit model
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= tbt_pkg::ST_IDLE;
			op_q <= tbt_pkg::OP_NONE;
			ph_q <= 2'b00;
			{addr_q, end_q, cur_q, data_q, ones_q, iomask_q} <= '0;
			{sig_q, sig_exp_q} <= '0;
			{mism_q, stfail_q, stdone_q} <= 3'b000;
			hsbad_q <= 8'h00;
			{tgt_addr_q, tgt_dout_q} <= '0;
			tgt_doe_q <= 1'b0;
			strobe_q <= 8'h00;
		end else if (ce) begin
			if (reg_wr && reg_addr == `TBT_OFF_ADDR) addr_q <= reg_wdata;
			if (reg_wr && reg_addr == `TBT_OFF_END) end_q <= reg_wdata;
			if (reg_wr && reg_addr == `TBT_OFF_SIGEXP) sig_exp_q <= reg_wdata[15:0];
			if (reg_wr && reg_addr == `TBT_OFF_DATA) data_q <= reg_wdata;
			if (stop_key) begin
				st_q <= tbt_pkg::ST_IDLE;
				{tgt_doe_q, strobe_q} <= 9'h000;
			end else if (st_q == tbt_pkg::ST_IDLE) begin
				if (cmd_ok) begin
					op_q <= tbt_pkg::tbt_op_e'(reg_wdata[2:0]);
					cur_q <= addr_q;
					ph_q <= 2'b00;
					sig_q <= 16'h0000;
					st_q <= tbt_pkg::ST_ADR;
					if (reg_wdata[2:0] == tbt_pkg::OP_SELFTEST) stdone_q <= 1'b0;
				end
			end else if (tick) begin
				case (st_q)
					tbt_pkg::ST_ADR: begin
						tgt_addr_q <= cur_q;
						tgt_dout_q <= cyc_wdat;
						tgt_doe_q <= cyc_wr;
						strobe_q <= 8'h04;
						st_q <= tbt_pkg::ST_STB;
					end
					tbt_pkg::ST_STB: begin
						strobe_q <= op_q == tbt_pkg::OP_HSCHK ? 8'hFF
							: {6'b000001, cyc_wr, ~cyc_wr};
						st_q <= tbt_pkg::ST_END;
					end
					tbt_pkg::ST_END: begin
						{tgt_doe_q, strobe_q} <= 9'h000;
						ph_q <= ph_q + 2'b01;
						st_q <= (op_last && !restart) ? tbt_pkg::ST_IDLE : tbt_pkg::ST_ADR;
						if (restart) begin
							cur_q <= addr_q;
							ph_q <= 2'b00;
						end
						case (op_q)
							tbt_pkg::OP_READ: data_q <= t_data;
							tbt_pkg::OP_ROMSIG: begin
								sig_q <= restart ? 16'h0000 : sig_nx;
								if (op_last) begin
									mism_q <= sig_nx != sig_exp_q;
									data_q <= {16'h0000, sig_nx};
								end else begin
									cur_q <= cur_q + 32'h00000001;
								end
							end
							tbt_pkg::OP_IOMASK: begin
								// bits that wrote one and zero back
								if (ph_q == 2'b01) ones_q <= t_data;
								if (ph_q == 2'b11) iomask_q <= ones_q & ~t_data;
							end
							tbt_pkg::OP_HSCHK: hsbad_q <= ~t_hsfb;
							tbt_pkg::OP_SELFTEST: begin
								if (ph_q == 2'b01) begin
									stfail_q <= t_data != `TBT_SELFTEST_PAT;
									stdone_q <= 1'b1;
								end
							end
							default: ;
						endcase
					end
					default: st_q <= tbt_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// supply loss, set wins over clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pwrf_q <= 1'b0;
		end else if (ce) begin
			if (!t_pwr) pwrf_q <= 1'b1;
			else if (reg_wr && reg_addr == `TBT_OFF_STATUS && reg_wdata[`TBT_ST_PWRF]) pwrf_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) ctrl_q <= 8'h00;
		else if (ce && reg_wr && reg_addr == `TBT_OFF_CTRL) ctrl_q <= reg_wdata[7:0];
	end

	// run state, one flag for loop and stop
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			run_q <= tbt_pkg::RUN_IDLE;
			mode_q <= tbt_pkg::MODE_NONE;
		end else if (ce) begin
			if (stop_key) begin
				run_q <= (run_q == tbt_pkg::RUN_LOOP || st_q != tbt_pkg::ST_IDLE)
					? tbt_pkg::RUN_STOP : tbt_pkg::RUN_IDLE;
			end else if (wr_mode && reg_wdata[1:0] == 2'b01) begin
				run_q <= tbt_pkg::RUN_LOOP;
			end else if (cmd_ok && run_q == tbt_pkg::RUN_STOP) begin
				run_q <= tbt_pkg::RUN_IDLE;
			end
			// one mode field, so modes exclude
			if (wr_mode && reg_wdata[3:2] != 2'b11) mode_q <= tbt_pkg::tbt_mode_e'(reg_wdata[3:2]);
		end
	end

	logic [7:0] dlen_q;
	logic [3:0] dlines_q, dline_q;
	logic [5:0] dcnt_q;
	wire [7:0] dvis = dlen_q > `TBT_DISP_CHARS ? `TBT_DISP_CHARS : dlen_q;
	wire more_lines = dline_q + 4'h1 < dlines_q;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dlen_q <= 8'h00;
			dlines_q <= 4'h0;
			dline_q <= 4'h0;
			dcnt_q <= 6'h00;
		end else if (ce) begin
			dcnt_q <= dvis[5:0];
			if (wr_disp) begin
				dlen_q <= reg_wdata[7:0];
				dlines_q <= reg_wdata[11:8];
				dline_q <= 4'h0;
			end else if (wr_mode && reg_wdata[`TBT_MODE_MORE] && more_lines) begin
				dline_q <= dline_q + 4'h1;
			end
		end
	end

	logic [31:0] fcnt_q;
	logic flash_q;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			fcnt_q <= 32'h00000000;
			flash_q <= 1'b0;
		end else if (ce) begin
			fcnt_q <= fcnt_q + 32'h00000001;
			if (fcnt_q >= 32'(FLASH_CYC - 1)) begin
				fcnt_q <= 32'h00000000;
				flash_q <= ~flash_q;
			end
		end
	end

	logic more_q, loop_q, stop_q, prog_q, exec_q;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			{more_q, loop_q, stop_q, prog_q, exec_q} <= 5'b00000;
		end else if (ce) begin
			more_q <= flash_q & more_lines;
			loop_q <= flash_q & (run_q == tbt_pkg::RUN_LOOP);
			stop_q <= flash_q & (run_q == tbt_pkg::RUN_STOP);
			prog_q <= flash_q & (mode_q == tbt_pkg::MODE_PROG);
			exec_q <= flash_q & (mode_q == tbt_pkg::MODE_EXEC);
		end
	end

	logic [9:0] pcfg_q;
	logic [31:0] pres_q;
	logic plast_q, pout_q, poe_q, prd_q;
	wire [1:0] psync = pcfg_q[5:4];
	wire pwin = psync == 2'b00 ? 1'b1 : psync == 2'b01 ? strobe_q[2] : |strobe_q[1:0];
	wire [15:0] psig_nx = sig_step(pres_q[15:0], t_probe);
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pcfg_q <= 10'h000;
			pres_q <= 32'h00000000;
			{plast_q, pout_q, poe_q, prd_q} <= 4'b0000;
		end else if (ce) begin
			plast_q <= t_probe;
			prd_q <= wr_prb && reg_wdata[`TBT_PRB_READ];
			poe_q <= 1'b0;
			if (wr_prb) begin
				pcfg_q <= reg_wdata[9:0];
				if (reg_wdata[`TBT_PRB_ARM]) pres_q <= 32'h00000000;
			end else if (pcfg_q[`TBT_PRB_ARM] && pwin) begin
				if (pcfg_q[1:0] != 2'b00) begin
					pout_q <= pcfg_q[1:0] == 2'b01;
					poe_q <= 1'b1;
					pcfg_q[`TBT_PRB_ARM] <= 1'b0;
				end
				case (pcfg_q[3:2])
					2'b00: pres_q[1:0] <= pres_q[1:0] | {t_probe, ~t_probe};
					2'b01: pres_q <= pres_q + {31'h00000000, t_probe & ~plast_q};
					2'b10: pres_q[15:0] <= psig_nx;
					default: ;
				endcase
			end
		end
	end

	logic [31:0] wreg_q [16];
	wire dflt = wr_cmd && reg_wdata[`TBT_CMD_DEFLT];
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 16; i++) wreg_q[i] <= `TBT_WREG_DEFLT;
		end else if (ce) begin
			if (wr_wreg) wreg_q[wreg_idx] <= reg_wdata;
			// probe read lands in register 0
			if (prd_q) wreg_q[0] <= pres_q;
			if (dflt) begin
				for (int i = 10; i < 16; i++) wreg_q[i] <= `TBT_WREG_DEFLT;
			end
		end
	end

	logic [7:0] mem_q [MEM_BYTES];
	logic [MAW-1:0] mema_q;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) mema_q <= '0;
		else if (ce && reg_wr && reg_addr == `TBT_OFF_MEMA) mema_q <= reg_wdata[MAW-1:0];
	end
	always_ff @(posedge ref_clk) begin
		if (ce && reg_wr && reg_addr == `TBT_OFF_MEMD) mem_q[mema_q] <= reg_wdata[7:0];
	end

	wire [31:0] status_w = {t_stat, 10'h000, t_plug, stdone_q, stfail_q, pwrf_q, mism_q,
		st_q != tbt_pkg::ST_IDLE};
	wire [31:0] rd_mux =
		reg_addr[7:6] == 2'b01 ? wreg_q[wreg_idx]
		: reg_addr == `TBT_OFF_CMD ? {29'h00000000, op_q}
		: reg_addr == `TBT_OFF_ADDR ? addr_q
		: reg_addr == `TBT_OFF_DATA ? data_q
		: reg_addr == `TBT_OFF_END ? end_q
		: reg_addr == `TBT_OFF_SIGEXP ? {16'h0000, sig_exp_q}
		: reg_addr == `TBT_OFF_STATUS ? status_w
		: reg_addr == `TBT_OFF_SIG ? {16'h0000, sig_q}
		: reg_addr == `TBT_OFF_IOMASK ? iomask_q
		: reg_addr == `TBT_OFF_CTRL ? {24'h000000, ctrl_q}
		: reg_addr == `TBT_OFF_HSBAD ? {24'h000000, hsbad_q}
		: reg_addr == `TBT_OFF_PROBE ? {22'h000000, pcfg_q}
		: reg_addr == `TBT_OFF_MODE ? {28'h0000000, mode_q, run_q}
		: reg_addr == `TBT_OFF_MEMA ? 32'(mema_q)
		: reg_addr == `TBT_OFF_MEMD ? {24'h000000, mem_q[mema_q]}
		: reg_addr == `TBT_OFF_DISP ? {16'h0000, dline_q, dlines_q, dlen_q}
		: 32'h00000000;
	logic [31:0] rdata_q;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) rdata_q <= 32'h00000000;
		else if (ce) rdata_q <= reg_rd ? rd_mux : 32'h00000000;
	end

	// bit 0 is the least significant everywhere
	assign reg_rdata = rdata_q;
	assign tgt_addr = tgt_addr_q;
	assign tgt_data_out = tgt_dout_q;
	assign tgt_data_oe = tgt_doe_q;
	assign tgt_ctrl_out = ctrl_q;
	assign tgt_strobe_out = strobe_q;
	assign probe_out = pout_q;
	assign probe_oe = poe_q;
	assign more_ind = more_q;
	assign loop_ind = loop_q;
	assign stop_ind = stop_q;
	assign program_entry_indicator = prog_q;
	assign exec_ind = exec_q;
	assign disp_first = 8'h00;
	assign disp_count = dcnt_q;
	assign disp_line = dline_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	sequence s_no_tick;
		!tick || !ce;
	endsequence
	bus_on_tick_a: assert property (
		s_no_tick and !stop_key and st_q != tbt_pkg::ST_IDLE |=> $stable(st_q))
		else $error("bus state moved without target clock edge");
	loop_stop_excl_a: assert property (!(loop_ind && stop_ind))
		else $error("repeat and halt indicators lit together");
	mode_excl_a: assert property (!(program_entry_indicator && exec_ind))
		else $error("program and run indicators lit together");
	more_lines_a: assert property ($rose(more_ind) |-> $past(more_lines))
		else $error("more indicator without further lines");
	pwr_fail_a: assert property (ce && !t_pwr |=> pwrf_q)
		else $error("supply loss not flagged");
	probe_reg0_a: assert property (ce && prd_q |=> wreg_q[0] == $past(pres_q))
		else $error("probe result not in register 0");
	disp_max_a: assert property (disp_count <= 6'h20)
		else $error("display window above 32 characters");
	selftest_plug_a: assert property (
		st_q == tbt_pkg::ST_IDLE && wr_cmd && ce && !stop_key
		&& reg_wdata[2:0] == tbt_pkg::OP_SELFTEST && !t_plug |=> st_q == tbt_pkg::ST_IDLE)
		else $error("self test started without plug");
	hs_drive_a: assert property (
		ce && tick && !stop_key && st_q == tbt_pkg::ST_STB && op_q == tbt_pkg::OP_HSCHK
		|=> tgt_strobe_out == 8'hFF)
		else $error("handshake check did not drive all strobes");
	defaults_a: assert property (ce && dflt && !wr_wreg |=> wreg_q[15] == `TBT_WREG_DEFLT)
		else $error("parameter register default not restored");
endmodule // tbt_core
`default_nettype wire

/* common/tbt_params.svh */
/*
 Constants of the target bus tester core: register byte offsets, field
 positions, reset values and timing counts. Included by the package user.
*/
`ifndef TBT_PARAMS_SVH
`define TBT_PARAMS_SVH
`define TBT_CLK_MHZ 100
`define TBT_FLASH_MS 250
`define TBT_OFF_CMD 8'h00
`define TBT_OFF_ADDR 8'h04
`define TBT_OFF_DATA 8'h08
`define TBT_OFF_END 8'h0C
`define TBT_OFF_SIGEXP 8'h10
`define TBT_OFF_STATUS 8'h14
`define TBT_OFF_SIG 8'h18
`define TBT_OFF_IOMASK 8'h1C
`define TBT_OFF_CTRL 8'h20
`define TBT_OFF_HSBAD 8'h24
`define TBT_OFF_PROBE 8'h28
`define TBT_OFF_MODE 8'h2C
`define TBT_OFF_MEMA 8'h30
`define TBT_OFF_MEMD 8'h34
`define TBT_OFF_DISP 8'h38
`define TBT_OFF_WREG 8'h40
`define TBT_ST_BUSY 0
`define TBT_ST_MISM 1
`define TBT_ST_PWRF 2
`define TBT_ST_STFAIL 3
`define TBT_ST_STDONE 4
`define TBT_ST_PLUG 5
`define TBT_ST_LINES 16
`define TBT_CMD_DEFLT 8
`define TBT_PRB_READ 9
`define TBT_PRB_ARM 8
`define TBT_MODE_MORE 4
`define TBT_SIG_POLY 16'h1021
`define TBT_SELFTEST_PAT 32'hA5A5A5A5
`define TBT_DISP_CHARS 8'h20
`define TBT_WREG_DEFLT 32'h00000000
`endif

/* common/tbt_pkg.sv */
/*
 Types of the target bus tester core. Constants live in tbt_params.svh.
*/
package tbt_pkg;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ADR = 2'b01, ST_STB = 2'b10,
		ST_END = 2'b11} tbt_bus_e;
	typedef enum logic [2:0] {OP_READ = 3'b000, OP_WRITE = 3'b001, OP_ROMSIG = 3'b010,
		OP_IOMASK = 3'b011, OP_HSCHK = 3'b100, OP_SELFTEST = 3'b101,
		OP_NONE = 3'b111} tbt_op_e;
	typedef enum logic [1:0] {RUN_IDLE = 2'b00, RUN_LOOP = 2'b01,
		RUN_STOP = 2'b10} tbt_run_e;
	typedef enum logic [1:0] {MODE_NONE = 2'b00, MODE_PROG = 2'b01,
		MODE_EXEC = 2'b10} tbt_mode_e;
endpackage

/* testbench/tbt_target_model.sv */
/*
 Target board model: free-running target clock, word memory, I/O words with
 stuck-low bits, handshake feedback. Assumes the core drives address and strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module tbt_target_model #(
	parameter int HALF_NS = 30
) (
	output logic tgt_clk,
	input wire logic [31:0] tgt_addr,
	input wire logic [31:0] tgt_data_out,
	input wire logic tgt_data_oe,
	input wire logic [7:0] tgt_strobe_out,
	input wire logic [7:0] hs_stuck,
	output logic [31:0] tgt_data_in,
	output logic [7:0] tgt_hs_fb
);
	logic [31:0] mem [logic [31:0]];
	logic [31:0] last;
	function automatic logic [31:0] word(input logic [31:0] a);
		logic [31:0] w;
		w = mem.exists(a) ? mem[a] : {a[15:0], ~a[15:0]};
		// upper half is I/O with bits stuck low
		return a[31] ? (w & 32'h0F0F00FF) : w;
	endfunction
	initial begin
		tgt_clk = 1'b0;
		last = 32'h0;
		forever #HALF_NS tgt_clk = ~tgt_clk;
	end
	always @(posedge tgt_clk) begin
		if (tgt_strobe_out[1] && tgt_data_oe)
			mem[tgt_addr] = tgt_data_out;
		if (tgt_strobe_out[0])
			last <= word(tgt_addr);
	end
	// Released bus shows the inverse, so a stale capture cannot pass
	always @*
		tgt_data_in = tgt_strobe_out[0] ? word(tgt_addr) : ~last;
	// stuck handshake lines read back low
	assign tgt_hs_fb = tgt_strobe_out & ~hs_stuck;
endmodule // tbt_target_model
`default_nettype wire

/* testbench/target_bus_tester_core_test.sv */
/*
 Bench for tbt_core: register tasks, behavioural register model, target model.
 Assumes the flash timer is shortened to 4 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tbt_params.svh"
module target_bus_tester_core_test;
	logic ref_clk, rst_b, reg_wr, reg_rd, pok, plug, probe_in, tclk, oe, mi, li, si, pi, ei;
	logic ce, p_out, p_oe;
	logic [3:0] dln;
	logic [7:0] reg_addr, stuck, ctl_o, strb, hs_fb;
	logic [31:0] reg_wdata, reg_rdata, v, d, a, t_addr, dout, din;
	logic [31:0] wreg [16];
	logic [15:0] stat_in, sig;
	logic [5:0] dcount;
	logic [4:0] ind;
	int errors, n_tests;
	tbt_core #(.FLASH_CYC(4)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .tgt_clk(tclk), .tgt_addr(t_addr), .tgt_data_out(dout),
		.tgt_data_oe(oe), .tgt_data_in(din), .tgt_status_in(stat_in), .tgt_ctrl_out(ctl_o),
		.tgt_strobe_out(strb), .tgt_hs_fb(hs_fb), .tgt_power_ok(pok),
		.selftest_plug_in(plug), .probe_in(probe_in), .probe_out(p_out), .probe_oe(p_oe),
		.more_ind(mi), .loop_ind(li), .stop_ind(si), .program_entry_indicator(pi),
		.exec_ind(ei), .disp_first(), .disp_count(dcount), .disp_line(dln));
	tbt_target_model tgt (.tgt_clk(tclk), .tgt_addr(t_addr), .tgt_data_out(dout),
		.tgt_data_oe(oe), .tgt_strobe_out(strb), .hs_stuck(stuck), .tgt_data_in(din),
		.tgt_hs_fb(hs_fb));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= wd;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [31:0] rv);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask
	task automatic rc(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
		rd(ad, v);
		check(v & m, e);
	endtask
	task automatic run(input logic [31:0] c);
		wr(`TBT_OFF_CMD, c);
		repeat (2) @(posedge ref_clk);
		v = 32'h1;
		for (int i = 0; i < 300 && v[0] !== 1'b0; i++)
			rd(`TBT_OFF_STATUS, v);
		// A hung bus op counts as a mismatch
		check(v & 32'h1, 32'h0);
	endtask
	task automatic pulses(input logic [31:0] cfg, input logic [31:0] e);
		wr(`TBT_OFF_PROBE, cfg);
		repeat (3) begin
			probe_in <= 1'b1;
			repeat (3) @(posedge ref_clk);
			probe_in <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
		repeat (4) @(posedge ref_clk);
		wr(`TBT_OFF_PROBE, 32'h200);
		repeat (4) @(posedge ref_clk);
		wreg[0] = e;
		rc(`TBT_OFF_WREG, 32'hFFFFFFFF, wreg[0]);
	endtask
	task automatic see(input logic [4:0] e);
		repeat (8) @(posedge ref_clk);
		ind = 5'h0;
		repeat (24) begin
			@(posedge ref_clk);
			#1;
			ind = ind | {mi, li, si, pi, ei};
		end
		check({27'h0, ind}, {27'h0, e});
	endtask
	task automatic wregs;
		for (int n = 0; n < 16; n++)
			rc(`TBT_OFF_WREG + 8'(4 * n), 32'hFFFFFFFF, wreg[n]);
	endtask
	function automatic logic [15:0] crc(input logic [31:0] w);
		logic [15:0] c, x;
		c = 16'h0;
		x = w[15:0] ^ w[31:16];
		for (int i = 15; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ x[i]) ? `TBT_SIG_POLY : 16'h0);
		return c;
	endfunction
	task automatic summarize;
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		#500_000;
		errors++;
		summarize();
	end
	initial begin
		void'($urandom(32'h3da46832));
		{rst_b, reg_wr, reg_rd, plug, probe_in} = 5'h0;
		{reg_addr, reg_wdata, stuck} = 48'h0;
		pok = 1'b1;
		ce = 1'b1;
		stat_in = 16'($urandom);
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rc(`TBT_OFF_STATUS, 32'hFFFF003F, {stat_in, 16'h0});
		rc(8'h3C, 32'hFFFFFFFF, 32'h0);
		for (int n = 0; n < 16; n++) begin
			wreg[n] = $urandom;
			wr(`TBT_OFF_WREG + 8'(4 * n), wreg[n]);
		end
		wregs();
		d = $urandom;
		wr(`TBT_OFF_CTRL, d);
		#1;
		check({24'h0, ctl_o}, {24'h0, d[7:0]});
		// Clock enable low must freeze the control register
		ce <= 1'b0;
		wr(`TBT_OFF_CTRL, ~d);
		ce <= 1'b1;
		#1;
		check({24'h0, ctl_o}, {24'h0, d[7:0]});
		a = {1'b0, 31'($urandom)};
		d = $urandom;
		wr(`TBT_OFF_ADDR, a);
		wr(`TBT_OFF_DATA, d);
		run(32'h1);
		wr(`TBT_OFF_DATA, 32'h0);
		run(32'h0);
		rc(`TBT_OFF_DATA, 32'hFFFFFFFF, d);
		// one-word block, expected then wrong reference
		sig = crc({16'h0200, 16'hFDFF});
		wr(`TBT_OFF_ADDR, 32'h200);
		wr(`TBT_OFF_END, 32'h200);
		for (int k = 0; k < 2; k++) begin
			wr(`TBT_OFF_SIGEXP, {16'h0, sig ^ 16'(k)});
			run(32'h2);
			rc(`TBT_OFF_SIG, 32'hFFFF, {16'h0, sig});
			rc(`TBT_OFF_STATUS, 32'h2, 32'(k) << 1);
		end
		wr(`TBT_OFF_ADDR, 32'h80000010);
		run(32'h3);
		rc(`TBT_OFF_IOMASK, 32'hFFFFFFFF, 32'h0F0F00FF);
		@(posedge ref_clk);
		stuck <= 8'($urandom);
		run(32'h4);
		rc(`TBT_OFF_HSBAD, 32'hFF, {24'h0, stuck});
		pok <= 1'b0;
		repeat (6) @(posedge ref_clk);
		pok <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rc(`TBT_OFF_STATUS, 32'h4, 32'h4);
		wr(`TBT_OFF_STATUS, 32'h4);
		rc(`TBT_OFF_STATUS, 32'h4, 32'h0);
		// self test refused without plug, then run with it
		wr(`TBT_OFF_ADDR, 32'h00000100);
		wr(`TBT_OFF_CMD, 32'h5);
		repeat (20) @(posedge ref_clk);
		rc(`TBT_OFF_STATUS, 32'h11, 32'h0);
		plug <= 1'b1;
		repeat (4) @(posedge ref_clk);
		run(32'h5);
		rc(`TBT_OFF_STATUS, 32'h39, 32'h30);
		// last byte of storage keeps its own value
		d = $urandom;
		wr(`TBT_OFF_MEMA, 32'h00002FFF);
		wr(`TBT_OFF_MEMD, d);
		wr(`TBT_OFF_MEMA, 32'h0);
		wr(`TBT_OFF_MEMD, ~d);
		wr(`TBT_OFF_MEMA, 32'h00002FFF);
		rc(`TBT_OFF_MEMD, 32'hFF, {24'h0, d[7:0]});
		// both levels seen, then three rising edges counted, copied into register 0
		pulses(32'h100, 32'h3);
		pulses(32'h104, 32'h3);
		// Address-valid sync: no bus cycle, so nothing is counted
		pulses(32'h114, 32'h0);
		for (int k = 1; k < 3; k++) begin
			wr(`TBT_OFF_PROBE, 32'h100 | 32'(k));
			@(posedge ref_clk);
			#1;
			check({30'h0, p_oe, p_out}, {30'h0, 1'b1, k == 1});
			@(posedge ref_clk);
			#1;
			check({31'h0, p_oe}, 32'h0);
		end
		run(32'h100);
		for (int n = 10; n < 16; n++)
			wreg[n] = `TBT_WREG_DEFLT;
		wregs();
		// long single line, then several lines
		wr(`TBT_OFF_DISP, 32'h128);
		see(5'h00);
		check({26'h0, dcount}, 32'h20);
		wr(`TBT_OFF_DISP, 32'h314);
		see(5'h10);
		check({26'h0, dcount}, 32'h14);
		wr(`TBT_OFF_DISP, 32'h114);
		wr(`TBT_OFF_MODE, 32'h1);
		see(5'h08);
		wr(`TBT_OFF_MODE, 32'h2);
		see(5'h04);
		wr(`TBT_OFF_MODE, 32'h4);
		see(5'h06);
		wr(`TBT_OFF_MODE, 32'h8);
		see(5'h05);
		wr(`TBT_OFF_DISP, 32'h314);
		repeat (2) wr(`TBT_OFF_MODE, 32'h1C);
		see(5'h05);
		check({28'h0, dln}, 32'h2);
		summarize();
	end
endmodule // target_bus_tester_core_test
`default_nettype wire
